// ==== rtl/gcs_ctrl.sv ====
// gcs_ctrl: control subcommand decoder, status word and power modes.
// assumes: framing outside; gauge on core clock.
`timescale 1ns/1ps

// Overview of operation
// R1 - host follows control command with a two-byte subcommand word
// R2 - 0x0000 puts control status word at the control addresses
// R3 - 0x0001..0x0003 return device type, firmware and silicon revision
// R4 - 0x0008 returns chemistry code, 0x000C flash image revision
// R5 - locked state refuses 0x0004-0x0007, 0x0010, 0x0020, 0x0021, 0x0040, 0x0041
// R6 - 0x0004 computes checksum only unlocked; stored checksum stays readable
// R7 - 0x0005 returns the count of resets performed
// R8 - 0x0007 returns previous subcommand, always below 0x0020
// R9 - 0x0010 sets deep-sleep flag; sleep entry then stops oscillator
// R10 - first single-wire message in deep sleep is dropped; host resends
// R11 - first I2C message in deep sleep stretches clock 6-8 ms
// R12 - any message in deep sleep returns to sleep, clears flag
// R13 - 0x0011 sets hibernate request; cleared on hibernate exit
// R14 - hibernate only in I2C mode, never single-wire
// R15 - 0x0012 clears hibernate request and forces hibernate exit
// R16 - 0x0013 lets shutdown pin follow the gauging decision
// R17 - 0x0014 freezes shutdown pin whatever the gauging decision
// R18 - 0x0015 sets, 0x0016 clears wire interrupt enable, both when locked
// R19 - 0x0020 unlocked enters locked state and sets locked flag
// R20 - unlocked: 0x0021 starts gauging, 0x0040 calibration, 0x0041 reset
// R21 - status word bit layout, pin active at 15, capacity update at 0
// R22 - reset: pin active, interrupt, hibernate, constant power 0; shutdown 1 (here pin active tracks shdn_cond_in, constant power gauge_in.const_power)
// R23 - reserved or unlisted codes change nothing
module gcs_ctrl
  import gcs_pkg::*;
#(
  parameter int          STRETCH_N = STRETCH_CYC,
  parameter logic [15:0] DEV_TYPE  = 16'h1234,  // arbitrary value
  parameter logic [15:0] FW_REV    = 16'h0100,  // arbitrary value
  parameter logic [15:0] HW_REV    = 16'h0001,  // arbitrary value
  parameter logic [15:0] CHEM_CODE = 16'h0100,  // arbitrary value
  parameter logic [15:0] FLASH_REV = 16'h0001   // arbitrary value
)(
  // core clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // link side
  input  wire logic        link_clk_in,
  input  wire logic        msg_start_in,
  input  wire logic [7:0]  byte_in,
  input  wire logic        byte_vld_in,
  input  wire logic        wire_mode_in,
  output logic             scl_stretch_out,
  // gauge and flash side
  input  wire gcs_gauge_t  gauge_in,
  input  wire logic        sleep_entry_in,
  input  wire logic        hib_wake_in,
  input  wire logic        shdn_cond_in,
  input  wire logic [15:0] flash_sum_in,
  input  wire logic [15:0] reset_count_in,
  // control word and mode outputs
  output logic [15:0]      resp_word_out,
  output gcs_status_t      status_out,
  output logic             osc_run_out,
  output logic             hibernate_out,
  output logic             gauge_start_out,
  output logic             cal_mode_out,
  output logic             full_reset_out,
  // shutdown pin
  output logic             shdn_pin_out,
  output logic             shdn_pin_oe_out
);

  logic [1:0]  rst_q;
  logic        rst_n;
  logic [15:0] lk_word;
  logic        lk_word_tgl;
  logic        lk_msg_tgl;
  logic [2:0]  sync_q;
  logic        wtgl_q;
  logic        mtgl_q;
  logic        word_ev;
  logic        msg_ev;
  logic        wire_mode;
  logic [15:0] cmd;
  logic        drop;
  logic        take;
  logic        allowed;
  logic        known;
  gcs_pmode_t  pm_q;
  gcs_pmode_t  pm_d;
  logic        deep_flag_q;
  logic        hib_req_q;
  logic        shdn_ctl_q;
  logic        wint_q;
  logic        locked_q;
  logic        csv_q;
  logic        vok_q;
  logic        qen_q;
  logic        cal_q;
  logic [15:0] sum_q;
  logic [15:0] last_q;
  logic [15:0] resp_q;
  logic [31:0] str_cnt_q;

  // ==========================================================
  // reset release through two flops
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rst_q <= 2'h0;
    else
      rst_q <= {rst_q[0], 1'b1};
  end

  assign rst_n = rst_q[1];

  // ==========================================================
  // link domain and crossings
  gcs_link_rx u_rx (
    .link_clk_in  (link_clk_in),
    .arst_n_in    (arst_n_in),
    .msg_start_in (msg_start_in),
    .byte_in      (byte_in),
    .byte_vld_in  (byte_vld_in),
    .word_out     (lk_word),
    .word_tgl_out (lk_word_tgl),
    .msg_tgl_out  (lk_msg_tgl)
  );

  gcs_sync #(.W(3)) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .d_in     ({wire_mode_in, lk_msg_tgl, lk_word_tgl}),
    .q_out    (sync_q)
  );

  // toggle edges into one-cycle events
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wtgl_q <= 1'b0;
      mtgl_q <= 1'b0;
    end
    else
    begin
      wtgl_q <= sync_q[0];
      mtgl_q <= sync_q[1];
    end
  end

  assign word_ev   = sync_q[0] ^ wtgl_q;
  assign msg_ev    = sync_q[1] ^ mtgl_q;
  assign wire_mode = sync_q[2];
  assign cmd       = lk_word;  // stable since toggle

  // ==========================================================
  // command acceptance
  // R10 - drop first wire word
  assign drop = (pm_q == PM_DEEP) && wire_mode;
  assign take = word_ev && !drop;

  // R23 - list of known codes
  always_comb
  begin
    unique case (cmd)
      SC_STATUS, SC_DEV_TYPE, SC_FW_REV, SC_HW_REV,
      SC_CHECKSUM, SC_RST_COUNT, SC_LAST_SC, SC_CHEM,
      SC_FLASH_REV, SC_DEEP_SET, SC_HIB_SET, SC_HIB_CLR,
      SC_SHDN_SET, SC_SHDN_CLR, SC_WINT_SET, SC_WINT_CLR,
      SC_LOCK, SC_GAUGE_GO, SC_CAL_MODE, SC_FULL_RST:
        known = 1'b1;
      default:
        known = 1'b0;
    endcase
  end

  // R5 - locked access filter
  always_comb
  begin
    unique case (cmd)
      SC_CHECKSUM, SC_RST_COUNT, SC_RSVD6, SC_LAST_SC,
      SC_DEEP_SET, SC_LOCK, SC_GAUGE_GO, SC_CAL_MODE,
      SC_FULL_RST:
        allowed = known && !locked_q;
      default:
        allowed = known;
    endcase
  end

  // ==========================================================
  // power mode machine
  always_comb
  begin
    pm_d = pm_q;
    unique case (pm_q)
      PM_RUN:
      begin
        // R14 - no hibernate on wire link
        if (sleep_entry_in && hib_req_q && !wire_mode)
          pm_d = PM_HIB;
        // R9 - deep sleep on sleep entry
        else if (sleep_entry_in && deep_flag_q)
          pm_d = PM_DEEP;
      end
      PM_DEEP:
      begin
        // R12 - message returns to sleep
        if (msg_ev || word_ev)
          pm_d = PM_RUN;
      end
      PM_HIB:
      begin
        // R15 - forced hibernate exit
        if (hib_wake_in || (take && cmd == SC_HIB_CLR))
          pm_d = PM_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      pm_q <= PM_RUN;
    else
      pm_q <= pm_d;
  end

  // ==========================================================
  // R11 - oscillator start stretch
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      str_cnt_q <= 32'h0;
    else if (pm_q == PM_DEEP && msg_ev && !wire_mode)
      str_cnt_q <= 32'(STRETCH_N);
    else if (str_cnt_q != 32'h0)
      str_cnt_q <= str_cnt_q - 32'h1;
  end

  assign scl_stretch_out = (str_cnt_q != 32'h0);
  assign osc_run_out     = (pm_q != PM_DEEP);
  assign hibernate_out   = (pm_q == PM_HIB);

  // ==========================================================
  // deep-sleep flag
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      deep_flag_q <= 1'b0;
    // R9 - set by command
    else if (take && allowed && cmd == SC_DEEP_SET)
      deep_flag_q <= 1'b1;
    // R12 - cleared by communication
    else if (pm_q == PM_DEEP && (msg_ev || word_ev))
      deep_flag_q <= 1'b0;
  end

  // ==========================================================
  // hibernate request
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      hib_req_q <= 1'b0;
    // R13 - set by command
    else if (take && cmd == SC_HIB_SET)
      hib_req_q <= 1'b1;
    // R15 - clear by command
    else if (take && cmd == SC_HIB_CLR)
      hib_req_q <= 1'b0;
    // R13 - auto clear on exit
    else if (pm_q == PM_HIB && pm_d == PM_RUN)
      hib_req_q <= 1'b0;
  end

  // ==========================================================
  // shutdown control and interrupt enable
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // R22 - shutdown control set
      shdn_ctl_q <= SHDN_CTL_RST;
      wint_q     <= 1'b0;
    end
    else if (take)
    begin
      // R16 - shutdown pin may toggle
      if (cmd == SC_SHDN_SET)
        shdn_ctl_q <= 1'b1;
      // R17 - shutdown pin frozen
      if (cmd == SC_SHDN_CLR)
        shdn_ctl_q <= 1'b0;
      // R18 - interrupt enable bit
      if (cmd == SC_WINT_SET)
        wint_q <= 1'b1;
      if (cmd == SC_WINT_CLR)
        wint_q <= 1'b0;
    end
  end

  // pin pulled low when allowed and needed
  assign shdn_pin_out    = 1'b0;
  assign shdn_pin_oe_out = shdn_ctl_q && shdn_cond_in;

  // ==========================================================
  // access lock, checksum and gauging flags
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      locked_q <= LOCKED_RST;
      csv_q    <= 1'b0;
      sum_q    <= 16'h0000;
      vok_q    <= 1'b0;
      qen_q    <= 1'b0;
      cal_q    <= 1'b0;
    end
    else
    begin
      // R19 - enter locked state
      if (take && allowed && cmd == SC_LOCK)
        locked_q <= 1'b1;
      // R6 - checksum only unlocked
      if (take && allowed && cmd == SC_CHECKSUM)
      begin
        sum_q <= flash_sum_in;
        csv_q <= 1'b1;
      end
      // R20 - gauging start sets flags
      if (take && allowed && cmd == SC_GAUGE_GO)
      begin
        vok_q <= 1'b1;
        qen_q <= 1'b1;
      end
      else if (gauge_in.voltage_bad)
        vok_q <= 1'b0;
      // R20 - calibration mode
      if (take && allowed && cmd == SC_CAL_MODE)
        cal_q <= 1'b1;
    end
  end

  // R20 - one-cycle action pulses
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gauge_start_out <= 1'b0;
      full_reset_out  <= 1'b0;
    end
    else
    begin
      gauge_start_out <= take && allowed && cmd == SC_GAUGE_GO;
      full_reset_out  <= take && allowed && cmd == SC_FULL_RST;
    end
  end

  assign cal_mode_out = cal_q;

  // ==========================================================
  // R21 - status word assembly
  always_comb
  begin
    status_out                    = '0;
    // R22 - pin active equals shdn_cond_in at reset, not clear
    status_out.pin_active         = shdn_ctl_q && shdn_cond_in;
    status_out.full_access_locked = gauge_in.full_access_locked;
    status_out.locked             = locked_q;
    status_out.checksum_valid     = csv_q;
    status_out.coulomb_cal        = gauge_in.coulomb_cal;
    status_out.board_cal          = gauge_in.board_cal;
    status_out.wire_int_en        = wint_q;
    status_out.shutdown           = shdn_ctl_q;
    status_out.hibernate          = hib_req_q;
    status_out.deep_sleep         = deep_flag_q;
    status_out.sleep              = gauge_in.sleep;
    status_out.const_power        = gauge_in.const_power;
    status_out.res_update_off     = gauge_in.res_update_off;
    status_out.voltage_ok         = vok_q;
    status_out.cap_update_en      = qen_q;
  end

  // ==========================================================
  // R8 - previous subcommand record
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      last_q <= 16'h0000;
    else if (take && allowed && cmd < LAST_SC_LIM)
      last_q <= cmd;
  end

  // ==========================================================
  // control address contents
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      resp_q <= RESP_RST;
    // R23 - refused codes other than locked 0x0004 leave it
    else if (take && allowed)
    begin
      unique case (cmd)
        // R2 - status word
        SC_STATUS:    resp_q <= status_out;
        // R3 - identity words
        SC_DEV_TYPE:  resp_q <= DEV_TYPE;
        SC_FW_REV:    resp_q <= FW_REV;
        SC_HW_REV:    resp_q <= HW_REV;
        // R6 - fresh checksum
        SC_CHECKSUM:  resp_q <= flash_sum_in;
        // R7 - reset count
        SC_RST_COUNT: resp_q <= reset_count_in;
        // R8 - previous code
        SC_LAST_SC:   resp_q <= last_q;
        // R4 - chemistry and image
        SC_CHEM:      resp_q <= CHEM_CODE;
        SC_FLASH_REV: resp_q <= FLASH_REV;
        default:      resp_q <= resp_q;
      endcase
    end
    // R6 - stored checksum readable locked
    else if (take && locked_q && cmd == SC_CHECKSUM)
      resp_q <= sum_q;
  end

  assign resp_word_out = resp_q;

endmodule

// ==== rtl/gcs_link_rx.sv ====
// gcs_link_rx: link-clock side; pairs command bytes into words.
// assumes: low byte first; word held to next pair.
`timescale 1ns/1ps
module gcs_link_rx
  import gcs_pkg::*;
(
  // link clock and reset
  input  wire logic        link_clk_in,
  input  wire logic        arst_n_in,
  // link byte stream
  input  wire logic        msg_start_in,
  input  wire logic [7:0]  byte_in,
  input  wire logic        byte_vld_in,
  // toward core domain
  output logic [15:0] word_out,
  output logic        word_tgl_out,
  output logic        msg_tgl_out
);

  logic [1:0] rst_q;
  logic       hi_next_q;
  logic [7:0] lo_q;

  // ==========================================================
  // reset release in link domain
  always_ff @(posedge link_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rst_q <= 2'h0;
    else
      rst_q <= {rst_q[0], 1'b1};
  end

  // ==========================================================
  // pairing; toggles per word, message
  always_ff @(posedge link_clk_in or negedge rst_q[1])
  begin
    if (!rst_q[1])
    begin
      hi_next_q    <= 1'b0;
      lo_q         <= 8'h00;
      word_out     <= 16'h0000;
      word_tgl_out <= 1'b0;
      msg_tgl_out  <= 1'b0;
    end
    else
    begin
      if (msg_start_in)
      begin
        hi_next_q   <= 1'b0;  // stray byte dropped
        msg_tgl_out <= ~msg_tgl_out;
      end
      else if (byte_vld_in && !hi_next_q)
      begin
        lo_q      <= byte_in;
        hi_next_q <= 1'b1;
      end
      else if (byte_vld_in)
      begin
        // R1 - two-byte subcommand
        word_out     <= {byte_in, lo_q};
        word_tgl_out <= ~word_tgl_out;
        hi_next_q    <= 1'b0;
      end
    end
  end

endmodule

// ==== rtl/gcs_pkg.sv ====
// gcs_pkg: constants and types of the decoder.
// assumes: a 100 MHz core clock and 16-bit subcommand words.
package gcs_pkg;

  // ==========================================================
  // subcommand codes
  localparam logic [15:0] SC_STATUS    = 16'h0000;
  localparam logic [15:0] SC_DEV_TYPE  = 16'h0001;
  localparam logic [15:0] SC_FW_REV    = 16'h0002;
  localparam logic [15:0] SC_HW_REV    = 16'h0003;
  localparam logic [15:0] SC_CHECKSUM  = 16'h0004;
  localparam logic [15:0] SC_RST_COUNT = 16'h0005;
  localparam logic [15:0] SC_RSVD6     = 16'h0006;
  localparam logic [15:0] SC_LAST_SC   = 16'h0007;
  localparam logic [15:0] SC_CHEM      = 16'h0008;
  localparam logic [15:0] SC_FLASH_REV = 16'h000C;
  localparam logic [15:0] SC_DEEP_SET  = 16'h0010;
  localparam logic [15:0] SC_HIB_SET   = 16'h0011;
  localparam logic [15:0] SC_HIB_CLR   = 16'h0012;
  localparam logic [15:0] SC_SHDN_SET  = 16'h0013;
  localparam logic [15:0] SC_SHDN_CLR  = 16'h0014;
  localparam logic [15:0] SC_WINT_SET  = 16'h0015;
  localparam logic [15:0] SC_WINT_CLR  = 16'h0016;
  localparam logic [15:0] SC_LOCK      = 16'h0020;
  localparam logic [15:0] SC_GAUGE_GO  = 16'h0021;
  localparam logic [15:0] SC_CAL_MODE  = 16'h0040;
  localparam logic [15:0] SC_FULL_RST  = 16'h0041;
  // last-code record limit
  localparam logic [15:0] LAST_SC_LIM  = 16'h0020;

  // ==========================================================
  // values after reset
  localparam logic        SHDN_CTL_RST = 1'b1;
  localparam logic        LOCKED_RST   = 1'b0;
  localparam logic [15:0] RESP_RST     = 16'h0000;

  // ==========================================================
  // oscillator restart stretch, least time 6 ms
  localparam int STRETCH_US  = 6000;
  localparam int CLK_MHZ     = 100;
  localparam int STRETCH_CYC = STRETCH_US * CLK_MHZ;

  // ==========================================================
  // control status word, bit 15 first
  typedef struct packed {
    logic pin_active;
    logic full_access_locked;
    logic locked;
    logic checksum_valid;
    logic coulomb_cal;
    logic board_cal;
    logic rsvd;
    logic wire_int_en;
    logic shutdown;
    logic hibernate;
    logic deep_sleep;
    logic sleep;
    logic const_power;
    logic res_update_off;
    logic voltage_ok;
    logic cap_update_en;
  } gcs_status_t;

  // gauge inputs for status
  typedef struct packed {
    logic full_access_locked;
    logic coulomb_cal;
    logic board_cal;
    logic sleep;
    logic const_power;
    logic res_update_off;
    logic voltage_bad;
  } gcs_gauge_t;

  // power modes
  typedef enum logic [1:0] {
    PM_RUN,
    PM_DEEP,
    PM_HIB
  } gcs_pmode_t;

endpackage

// ==== rtl/gcs_sync.sv ====
// gcs_sync: two-flop synchroniser for a vector of levels.
// assumes: slow levels or toggles, bit by bit.
`timescale 1ns/1ps
module gcs_sync
  import gcs_pkg::*;
#(
  parameter int W = 1
)(
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_q;

  // ==========================================================
  // two stages, first read only by the second
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_q <= '0;
      q_out  <= '0;
    end
    else
    begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end

endmodule

// ==== tb/gauge_control_subcommand_decoder_bench.sv ====
// bench: self-checks gcs_ctrl against a model.
// assumes: host model drives the link.
`timescale 1ns/1ps
module gauge_control_subcommand_decoder_bench;
  import gcs_pkg::*;
  // ==========================================
  // short stretch, arbitrary identities
  localparam int          SN  = 20;
  localparam logic [15:0] DEV = 16'h5A01;
  localparam logic [15:0] FWR = 16'h0203;
  localparam logic [15:0] HWR = 16'h0405;
  localparam logic [15:0] CHM = 16'h0607;
  localparam logic [15:0] FLR = 16'h0809;
  // design inputs and outputs
  logic        clk_in = 1'b0, arst_n_in = 1'b0, wire_mode_in = 1'b0, sleep_entry_in = 1'b0;
  logic        hib_wake_in = 1'b0, shdn_cond_in = 1'b0;
  logic [15:0] flash_sum_in = 16'h0000, reset_count_in = 16'h0000, resp_word_out;
  gcs_gauge_t  gauge_in = '0;
  gcs_status_t status_out;
  logic [7:0]  byte_in;
  logic        link_clk_in, msg_start_in, byte_vld_in, scl_stretch_out, osc_run_out;
  logic        hibernate_out, gauge_start_out, cal_mode_out, full_reset_out;
  logic        shdn_pin_out, shdn_pin_oe_out;
  // model state and tallies
  int          err_total = 0, comparisons = 0, seed, go_n = 0, rs_n = 0, st_n = 0;
  int          locked = 0, wint = 0, shdn = 1, hib = 0, deep = 0, checksum_valid_flag = 0, capacity_update_enable = 0;
  int          cal = 0, csum = 0, last_sc = 0, resp = 0, dozing = 0, hibing = 0;
  logic [15:0] open_codes [$] = {16'h0, 16'h1, 16'h2, 16'h3, 16'h8, 16'hC, 16'h4, 16'h5,
    16'h7, 16'h6, 16'h9, 16'h7, 16'h13, 16'h14, 16'h0, 16'h15, 16'h0, 16'h16, 16'h21,
    16'h40, 16'h41, 16'h0};
  logic [15:0] shut_codes [$] = {16'h4, 16'h5, 16'h6, 16'h7, 16'h10, 16'h21, 16'h40, 16'h41,
    16'h20, 16'h15, 16'h0, 16'h1, 16'h2, 16'h3, 16'h8, 16'hC, 16'h16, 16'h13, 16'h0};

  gcs_ctrl #(.STRETCH_N(SN), .DEV_TYPE(DEV), .FW_REV(FWR), .HW_REV(HWR), .CHEM_CODE(CHM),
    .FLASH_REV(FLR)) i_dut (.*);
  gcs_host_model i_host (.link_clk_out(link_clk_in), .msg_start_out(msg_start_in),
    .byte_vld_out(byte_vld_in), .byte_out(byte_in));

  // ==========================================
  // clock and pulse tallies
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    go_n += int'(gauge_start_out === 1'b1);
    rs_n += int'(full_reset_out === 1'b1);
    st_n += int'(scl_stretch_out === 1'b1);
  end

  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] exp_status();
    return {shdn[0] & shdn_cond_in, gauge_in.full_access_locked, locked[0], checksum_valid_flag[0],
      gauge_in.coulomb_cal, gauge_in.board_cal, 1'b0, wint[0], shdn[0], hib[0], deep[0],
      gauge_in.sleep, gauge_in.const_power, gauge_in.res_update_off, capacity_update_enable[0], capacity_update_enable[0]};
  endfunction
  function automatic logic [15:0] pins_e();
    return {12'h0, shdn[0] & shdn_cond_in, cal[0], ~dozing[0], hibing[0]};
  endfunction

  task automatic check_all();
    chk(resp_word_out, 16'(resp));
    chk(status_out, exp_status());
    chk({12'h0, shdn_pin_oe_out, cal_mode_out, osc_run_out, hibernate_out}, pins_e());
  endtask

  // one subcommand, then the model
  task automatic cmd(input logic [15:0] c, input bit st = 1'b1);
    bit ok;
    @(posedge clk_in);
    flash_sum_in   <= 16'($urandom);
    reset_count_in <= 16'($urandom);
    shdn_cond_in   <= 1'($urandom);
    gauge_in       <= gcs_gauge_t'(7'($urandom) & 7'h7E);
    i_host.send_word(c, st);
    repeat (10) @(posedge clk_in);
    ok = !(locked && (c inside {[16'h4:16'h7], 16'h10, 16'h20, 16'h21, 16'h40, 16'h41}));
    ok = ok && !(dozing && wire_mode_in);
    deep = dozing ? 0 : deep;
    dozing = 0;
    if (ok)
      case (c)
        SC_STATUS:    resp = exp_status();
        SC_DEV_TYPE:  resp = DEV;
        SC_FW_REV:    resp = FWR;
        SC_HW_REV:    resp = HWR;
        SC_CHEM:      resp = CHM;
        SC_FLASH_REV: resp = FLR;
        SC_CHECKSUM:  resp = flash_sum_in;
        SC_RST_COUNT: resp = reset_count_in;
        SC_LAST_SC:   resp = last_sc;
        SC_DEEP_SET:  deep = 1;
        SC_HIB_SET:   hib = 1;
        SC_HIB_CLR:   hib = 0;
        SC_SHDN_SET:  shdn = 1;
        SC_SHDN_CLR:  shdn = 0;
        SC_WINT_SET:  wint = 1;
        SC_WINT_CLR:  wint = 0;
        SC_LOCK:      locked = 1;
        SC_GAUGE_GO:  capacity_update_enable = 1;
        SC_CAL_MODE:  cal = 1;
        SC_FULL_RST:  ok = 1;
        default:      ok = 0;
      endcase
    resp = (locked && c == 16'h4) ? csum : resp;
    csum = (ok && c == 16'h4) ? resp : csum;
    checksum_valid_flag = (ok && c == 16'h4) ? 1 : checksum_valid_flag;
    last_sc = (ok && c < LAST_SC_LIM) ? int'(c) : last_sc;
    hibing = hibing && hib;
    check_all();
  endtask

  // sleep entry or hibernate wake pulse
  task automatic pulse(input bit wake);
    @(posedge clk_in);
    sleep_entry_in <= !wake;
    hib_wake_in    <= wake;
    @(posedge clk_in);
    sleep_entry_in <= 1'b0;
    hib_wake_in    <= 1'b0;
    repeat (3) @(posedge clk_in);
    hib = wake ? 0 : hib;
    hibing = !wake && hib && !wire_mode_in;
    dozing = !wake && !hibing && deep;
    check_all();
  endtask

  task automatic set_wire(input bit v);
    @(posedge clk_in);
    wire_mode_in <= v;
    repeat (4) @(posedge clk_in);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================
  // watchdog
  initial
  begin
    #200000;
    err_total++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    seed = $urandom(32'h9211FE11);
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    i_host.idle(3);
    repeat (3) @(posedge clk_in);
    check_all();
    foreach (open_codes[i])
      cmd(open_codes[i]);
    // deep sleep, I2C then wire
    cmd(SC_DEEP_SET);
    pulse(1'b0);
    cmd(SC_STATUS);
    set_wire(1'b1);
    cmd(SC_DEEP_SET);
    pulse(1'b0);
    cmd(SC_DEV_TYPE, 1'b0);
    cmd(SC_DEV_TYPE);
    // hibernate: wire, wake, command
    cmd(SC_HIB_SET);
    pulse(1'b0);
    set_wire(1'b0);
    pulse(1'b0);
    pulse(1'b1);
    cmd(SC_HIB_SET);
    pulse(1'b0);
    cmd(SC_HIB_CLR);
    cmd(SC_LOCK);
    foreach (shut_codes[i])
      cmd(shut_codes[i]);
    chk(16'(go_n), 16'h0001);
    chk(16'(rs_n), 16'h0001);
    chk(16'(st_n), 16'(SN));
    wrap_up();
  end
endmodule

// ==== tb/gcs_ctrl_checker.sv ====
// gcs_ctrl_checker: port checks.
// assumes: bound into gcs_ctrl; core clock.
`timescale 1ns/1ps
module gcs_ctrl_checker
  import gcs_pkg::*;
#(
  parameter int STRETCH_N = STRETCH_CYC
)(
  // clock and reset
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  // observed ports
  input wire logic        sleep_entry_in,
  input wire logic        hib_wake_in,
  input wire logic        shdn_cond_in,
  input wire logic        scl_stretch_out,
  input wire gcs_status_t status_out,
  input wire logic        osc_run_out,
  input wire logic        hibernate_out,
  input wire logic        gauge_start_out,
  input wire logic        cal_mode_out,
  input wire logic        full_reset_out,
  input wire logic        shdn_pin_out,
  input wire logic        shdn_pin_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  // ==========================================
  // stretch length
  int hi_q;
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      hi_q <= 0;
    else
      hi_q <= scl_stretch_out ? hi_q + 1 : 0;
  end

  // ==========================================
  // shutdown pin and reserved status bit
  a_pin_pulls_low: assert property (shdn_pin_out == 1'b0)
    else $error("shutdown pin driven high");
  a_pin_follows: assert property (shdn_pin_oe_out == (status_out.shutdown && shdn_cond_in))
    else $error("pin enable wrong");
  a_pin_active_bit: assert property (status_out.pin_active == shdn_pin_oe_out)
    else $error("pin active bit wrong");
  a_rsvd_bit_zero: assert property (status_out.rsvd == 1'b0)
    else $error("reserved status bit set");
  // power modes
  a_osc_stop_cause: assert property ($fell(osc_run_out) |-> $past(sleep_entry_in) && status_out.deep_sleep)
    else $error("oscillator stop uncaused");
  a_osc_wake_clear: assert property ($rose(osc_run_out) |-> ##[0:2] !status_out.deep_sleep)
    else $error("deep flag kept on wake");
  a_hib_has_req: assert property ($rose(hibernate_out) |-> status_out.hibernate)
    else $error("hibernate without request");
  a_hib_wake_exit: assert property (hibernate_out && hib_wake_in |-> ##[1:2] !hibernate_out && !status_out.hibernate)
    else $error("hibernate not left on wake");
  // unlocked actions and stretch length
  a_qen_after_go: assert property (gauge_start_out |-> ##[0:1] status_out.cap_update_en)
    else $error("no capacity update");
  a_qen_sticky: assert property (status_out.cap_update_en |=> status_out.cap_update_en)
    else $error("capacity update cleared");
  a_reset_one_shot: assert property (full_reset_out |=> !full_reset_out)
    else $error("full reset not a pulse");
  a_stretch_len: assert property ($fell(scl_stretch_out) |-> hi_q == STRETCH_N)
    else $error("stretch length wrong");
endmodule

bind gcs_ctrl gcs_ctrl_checker #(.STRETCH_N(STRETCH_N)) i_chk (.*);

// ==== tb/gcs_host_model.sv ====
// gcs_host_model: link clock and bytes.
// assumes: clock idles low between messages.
`timescale 1ns/1ps
module gcs_host_model
(
  // link toward the gauge
  output logic       link_clk_out,
  output logic       msg_start_out,
  output logic       byte_vld_out,
  output logic [7:0] byte_out
);
  // ==========================================
  // idle levels at time zero
  initial
  begin
    link_clk_out  = 1'b0;
    msg_start_out = 1'b0;
    byte_vld_out  = 1'b0;
    byte_out      = 8'h5A;
  end

  // clock periods, in messages and after reset
  task automatic idle(input int n);
    repeat (n)
    begin
      #24 link_clk_out = 1'b1;
      #24 link_clk_out = 1'b0;
    end
  endtask

  // marker, then word, low byte first
  task automatic send_word(input logic [15:0] w, input bit st);
    msg_start_out = st;
    idle(1);
    msg_start_out = 1'b0;
    byte_out      = w[7:0];
    byte_vld_out  = 1'b1;
    idle(1);
    byte_out      = w[15:8];
    idle(1);
    // released data shows inverse
    byte_vld_out  = 1'b0;
    byte_out      = ~w[15:8];
    idle(2);
  endtask
endmodule
